// [src/ebt_regs.sv]
// wishbone register bank for external bus area timing
`timescale 1ns/100ps
`default_nettype none
`include "ebt_defines.svh"
module ebt_regs
   import ebt_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic [2:0]  acc_area,
   output logic      [2:0]  wait_states,
   output logic             early_negate,
   output logic             sample_early,
   output logic             burst_sel,
   output logic      [3:0]  burst_states,
   output logic      [5:0]  burst_words
);
   ebt_byte_t   wait01_r, rdstb_r, brom0_r, brom1_r, astate_r;
   ebt_byte_t   rd_data;
   ebt_bus_st_t st_r, st_nxt;
   logic [31:0] dat_r;
   logic        ack_r, err_r;
   logic [2:0]  ws_c;
   logic        en_c, bs_c;
   logic [3:0]  bst_c;
   logic [5:0]  bw_c;
   logic [2:0]  ws_r;
   logic        en_r, bs_r;
   logic [3:0]  bst_r;
   logic [5:0]  bw_r;

   // address decode
   wire req      = wb_cyc_i && wb_stb_i && (st_r == EBT_IDLE);
   wire hit_w01  = wb_adr_i == `EBT_OFS_WAIT01;
   wire hit_rd   = wb_adr_i == `EBT_OFS_RDSTB;
   wire hit_b0   = wb_adr_i == `EBT_OFS_BROM0;
   wire hit_b1   = wb_adr_i == `EBT_OFS_BROM1;
   wire hit_as   = wb_adr_i == `EBT_OFS_ASTATE;
   wire hit_st   = wb_adr_i == `EBT_OFS_STATUS;
   wire mapped   = hit_w01 || hit_rd || hit_b0 || hit_b1 || hit_as || hit_st;
   wire wr_lane0 = req && mapped && wb_we_i && wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];

   // read mux, status shows decoded timing of acc_area
   assign rd_data = hit_w01 ? wait01_r :
                    hit_rd  ? rdstb_r  :
                    hit_b0  ? brom0_r  :
                    hit_b1  ? brom1_r  :
                    hit_as  ? astate_r :
                    hit_st  ? {bs_r, en_r, 3'h0, ws_r} : 8'h00;

   // bus state machine: one-cycle answer, then release
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         EBT_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               st_nxt = EBT_ACK;
            end
         end
         EBT_ACK:  st_nxt = EBT_HOLD;
         EBT_HOLD: begin
            if (!(wb_cyc_i && wb_stb_i)) begin
               st_nxt = EBT_IDLE;
            end
         end
         default:  st_nxt = EBT_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r <= EBT_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // answer registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req && mapped;
         err_r <= req && !mapped;
         dat_r <= (req && mapped && !wb_we_i) ? {24'h00_0000, rd_data} : 32'h0000_0000;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = dat_r;

   // register writes, reserved bits forced to zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wait01_r <= `EBT_RST_WAIT01;
         rdstb_r  <= `EBT_RST_RDSTB;
         brom0_r  <= `EBT_RST_BROM;
         brom1_r  <= `EBT_RST_BROM;
         astate_r <= `EBT_RST_ASTATE;
      end else begin
         if (wr_lane0 && hit_w01) begin
            wait01_r <= wd & `EBT_MASK_WAIT01;
         end
         if (wr_lane0 && hit_rd) begin
            rdstb_r <= wd;
         end
         if (wr_lane0 && hit_b0) begin
            brom0_r <= wd & `EBT_MASK_BROM;
         end
         if (wr_lane0 && hit_b1) begin
            brom1_r <= wd & `EBT_MASK_BROM;
         end
         if (wr_lane0 && hit_as) begin
            astate_r <= wd;
         end
      end
   end

   // decode of the current access area
   ebt_area_timing #(
      .AREAS (8)
   ) u_timing (
      .area         (acc_area),
      .wait01       (wait01_r),
      .astate       (astate_r),
      .rdstb        (rdstb_r),
      .brom0        (brom0_r),
      .brom1        (brom1_r),
      .wait_states  (ws_c),
      .early_negate (en_c),
      .burst_sel    (bs_c),
      .burst_states (bst_c),
      .burst_words  (bw_c)
   );

   // registered timing outputs for the sequencer
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ws_r  <= 3'h0;
         en_r  <= 1'b0;
         bs_r  <= 1'b0;
         bst_r <= 4'h1;
         bw_r  <= 6'h04;
      end else begin
         ws_r  <= ws_c;
         en_r  <= en_c;
         bs_r  <= bs_c;
         bst_r <= bst_c;
         bw_r  <= bw_c;
      end
   end
   assign wait_states  = ws_r;
   assign early_negate = en_r;
   assign sample_early = en_r;
   assign burst_sel    = bs_r;
   assign burst_states = bst_r;
   assign burst_words  = bw_r;

   // checks
   a_wait_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
      (wait01_r[7] == 1'b0) && (wait01_r[3] == 1'b0))
      else $error("reserved wait bits not zero");
   a_brom_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
      (brom0_r[3:2] == 2'b00) && (brom1_r[3:2] == 2'b00))
      else $error("reserved burst bits not zero");
   a_area1_wait_map: assert property (@(posedge ref_clk) disable iff (srst)
      (acc_area == 3'h1 && astate_r[1]) |=> (wait_states == $past(wait01_r[6:4])))
      else $error("area 1 wait count wrong");
   a_area0_wait_map: assert property (@(posedge ref_clk) disable iff (srst)
      (acc_area == 3'h0 && astate_r[0]) |=> (wait_states == $past(wait01_r[2:0])))
      else $error("area 0 wait count wrong");
   a_two_state_nowait: assert property (@(posedge ref_clk) disable iff (srst)
      !astate_r[acc_area] |=> (wait_states == 3'h0))
      else $error("wait states on two-state area");
   a_strobe_late: assert property (@(posedge ref_clk) disable iff (srst)
      !rdstb_r[acc_area] |=> !early_negate)
      else $error("early negation with bit clear");
   a_strobe_early: assert property (@(posedge ref_clk) disable iff (srst)
      (rdstb_r[acc_area] && !bs_c) |=> (early_negate && sample_early))
      else $error("missing early negation");
   a_burst_high_areas: assert property (@(posedge ref_clk) disable iff (srst)
      (acc_area > 3'h1) |=> !burst_sel)
      else $error("burst on area above 1");
   a_burst_select: assert property (@(posedge ref_clk) disable iff (srst)
      (acc_area == 3'h1) |=> (burst_sel == $past(brom1_r[7])))
      else $error("burst select wrong");
   a_burst_length: assert property (@(posedge ref_clk) disable iff (srst)
      (acc_area == 3'h0) |=> (burst_states == {1'b0, $past(brom0_r[6:4])} + 4'h1))
      else $error("burst length wrong");
   a_burst_words: assert property (@(posedge ref_clk) disable iff (srst)
      (acc_area == 3'h0 && brom0_r[1:0] == 2'b11) |=> (burst_words == 6'h20))
      else $error("burst word limit wrong");
   a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (srst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// [src/ebt_defines.svh]
// offsets, field positions, reset values and timing counts for the bus area timing registers
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH
`define EBT_OFS_WAIT01      8'h00
`define EBT_OFS_RDSTB       8'h04
`define EBT_OFS_BROM0       8'h08
`define EBT_OFS_BROM1       8'h0C
`define EBT_OFS_ASTATE      8'h10
`define EBT_OFS_STATUS      8'h14
`define EBT_RST_WAIT01      8'h77
`define EBT_RST_RDSTB       8'h00
`define EBT_RST_BROM        8'h00
`define EBT_RST_ASTATE      8'h03
`define EBT_MASK_WAIT01     8'h77
`define EBT_MASK_BROM       8'hF3
`define EBT_BIT_BSEL        7
`define EBT_POS_BLEN        4
`define EBT_POS_BWRD        0
`define EBT_POS_W1          4
`define EBT_POS_W0          0
`define EBT_CLK_PERIOD_NS   100
`define EBT_HALF_STATE_NS   50
`endif

// [src/ebt_pkg.sv]
// types shared by the bus area timing register bank
package ebt_pkg;
   typedef enum logic [2:0] {
      EBT_IDLE = 3'b001,
      EBT_ACK  = 3'b010,
      EBT_HOLD = 3'b100
   } ebt_bus_st_t;
   typedef logic [7:0] ebt_byte_t;
endpackage

// [src/ebt_area_timing.sv]
// per-area timing decode from the register contents
`timescale 1ns/100ps
`default_nettype none
`include "ebt_defines.svh"
module ebt_area_timing
   import ebt_pkg::*;
#(
   parameter int AREAS = 8
) (
   input  wire logic [2:0]       area,
   input  wire logic [7:0]       wait01,
   input  wire logic [7:0]       astate,
   input  wire logic [7:0]       rdstb,
   input  wire logic [7:0]       brom0,
   input  wire logic [7:0]       brom1,
   output logic      [2:0]       wait_states,
   output logic                  early_negate,
   output logic                  burst_sel,
   output logic      [3:0]       burst_states,
   output logic      [5:0]       burst_words
);
   // pick burst register of the area
   function automatic logic [7:0] brom_of(input logic [2:0] a, input logic [7:0] b0, input logic [7:0] b1);
      brom_of = (a == 3'h0) ? b0 : b1;
   endfunction
   wire        lo_area  = (area == 3'h0) || (area == 3'h1);
   wire [7:0]  brom_sel = brom_of(area, brom0, brom1);
   wire        three_st = astate[area];
   wire [2:0]  wfield   = (area == 3'h1) ? wait01[`EBT_POS_W1 +: 3] : wait01[`EBT_POS_W0 +: 3];
   // wait states only for three-state areas 0 and 1
   assign wait_states  = (lo_area && three_st) ? wfield : 3'h0;
   assign burst_sel    = lo_area && brom_sel[`EBT_BIT_BSEL];
   // early negation only on basic interface reads
   assign early_negate = rdstb[area] && !burst_sel;
   assign burst_states = {1'b0, brom_sel[`EBT_POS_BLEN +: 3]} + 4'h1;
   assign burst_words  = 6'h04 << brom_sel[`EBT_POS_BWRD +: 2];
endmodule
`default_nettype wire

// [verif/ebt_seq_model.sv]
// bus sequencer model: picks the access area each cycle
`timescale 1ns/100ps
`default_nettype none
module ebt_seq_model (
   input  wire logic       ref_clk,
   output logic      [2:0] acc_area,
   output logic      [2:0] area_q
);
   // a fresh area every cycle, and the area the bank just sampled
   always @(posedge ref_clk) begin
      area_q   <= acc_area;
      acc_area <= 3'($urandom);
   end
   initial acc_area = 3'h0;
endmodule
`default_nettype wire

// [verif/ext_bus_area_timing_cfg_tb.sv]
// self-checking bench for the bus area timing register bank
`timescale 1ns/100ps
`default_nettype none
module ext_bus_area_timing_cfg_tb
   import ebt_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        srst    = 1'b1;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [3:0]  sel     = 4'h0;
   logic [31:0] wdat    = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        err;
   logic [2:0]  area;
   logic [2:0]  area_q;
   logic [2:0]  ws;
   logic        en;
   logic        se;
   logic        bs;
   logic [3:0]  bst;
   logic [5:0]  bwd;
   logic [31:0] rd;
   logic        e;
   logic        bsx;
   ebt_byte_t   m [5];
   int          fail_count = 0;
   int          num_checks = 0;
   int          skip       = 4;

   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;

   ebt_regs dut (
      .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .acc_area(area), .wait_states(ws), .early_negate(en),
      .sample_early(se), .burst_sel(bs), .burst_states(bst), .burst_words(bwd)
   );

   ebt_seq_model u_seq (.ref_clk(ref_clk), .acc_area(area), .area_q(area_q));

   // compare one result and count it
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask

   task automatic end_of_test;
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // classic single wishbone cycle, model updated at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      skip = 3;
      @(posedge ref_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (!(ack === 1'b1 || err === 1'b1) && i < 20);
      // no answer within the limit counts as a mismatch
      if (!(ack === 1'b1 || err === 1'b1)) begin
         fail_count++;
         $display("BAD wb_answer exp 1 got 0");
      end
      rd = rdat;
      e = err;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (w && ack === 1'b1 && a < 8'h14)
         m[a[4:2]] = d[7:0] & (a == 8'h00 ? 8'h77 : (a[3] ? 8'hF3 : 8'hFF));
      skip = 3;
   endtask

   // timing outputs against the register model, area sampled one edge back
   always @(negedge ref_clk) begin
      if (skip > 0) skip--;
      else begin
         bsx = area_q < 3'h2 && m[2 + area_q][7];
         chk("burst_sel", bsx, bs);
         chk("early_negate", m[1][area_q] & ~bsx, en);
         chk("sample_early", m[1][area_q] & ~bsx, se);
         if (area_q < 3'h2) begin
            chk("wait_states", m[4][area_q] ? (m[0] >> (4 * area_q)) & 8'h07 : 0, ws);
            chk("burst_states", m[2 + area_q][6:4] + 32'h1, bst);
            chk("burst_words", 32'h4 << m[2 + area_q][1:0], bwd);
         end
      end
   end

   // reset values, unmapped address, reserved bits, then random traffic
   initial begin
      logic [7:0] a;
      void'($urandom(27677));
      m = '{8'h77, 8'h00, 8'h00, 8'h00, 8'h03};
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      foreach (m[i]) begin
         wb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", m[i], rd);
      end
      wb(1'b0, 8'h18, 32'h0);
      chk("unmapped err", 32'h1, e);
      wb(1'b1, 8'h00, 32'hFF);
      wb(1'b1, 8'h08, 32'hFF);
      wb(1'b1, 8'h0C, 32'h0F);
      foreach (m[i]) begin
         wb(1'b0, 8'(4 * i), 32'h0);
         chk("reserved bits", m[i], rd);
      end
      repeat (60) begin
         a = 8'($urandom_range(4)) << 2;
         wb(1'b1, a, $urandom);
         repeat (16) @(posedge ref_clk);
         wb(1'b0, a, 32'h0);
         chk("read back", m[a[4:2]], rd);
      end
      end_of_test;
   end

   // watchdog well past the expected run length
   initial begin
      #2000000;
      fail_count++;
      end_of_test;
   end
endmodule
`default_nettype wire
